// ### lcrs_consts.svh
// Register offsets, field positions, reset values and encodings
// Assumes inclusion by lcrs_pkg and lcrs_alu only
`ifndef LCRS_CONSTS_SVH
`define LCRS_CONSTS_SVH

`define LCRS_ADR_W       8
`define LCRS_ADR_OPA_LO  8'h00
`define LCRS_ADR_OPA_HI  8'h04
`define LCRS_ADR_OPB_LO  8'h08
`define LCRS_ADR_OPB_HI  8'h0c
`define LCRS_ADR_DST_LO  8'h10
`define LCRS_ADR_DST_HI  8'h14
`define LCRS_ADR_INSN    8'h18
`define LCRS_ADR_PFX_LO  8'h1c
`define LCRS_ADR_PFX_HI  8'h20
`define LCRS_ADR_STATUS  8'h24

`define LCRS_ST_CARRY    0
`define LCRS_ST_ILLEGAL  1
`define LCRS_ST_NOPFX    2
`define LCRS_ST_PFXV     3

`define LCRS_RST_CARRY   1'b0

`define LCRS_OPC_PCMP_EQ 6'h22
`define LCRS_OPC_PCMP_NE 6'h23
`define LCRS_FN_PCMP     11'h500
`define LCRS_FN_RSUB     11'h100
`define LCRS_OPC_RSUBI2  6'h1a
`define LCRS_BIT_K3      28
`define LCRS_BIT_C4      27
`define LCRS_BIT_K13     18
`define LCRS_BIT_C14     17

`endif

// ### lcrs_pkg.sv
// Types shared by the long compare / reverse-subtract unit
// Assumes lcrs_consts.svh is on the include path
package lcrs_pkg;
  `include "lcrs_consts.svh"

  typedef struct packed {
    logic                   cyc;
    logic                   stb;
    logic                   we;
    logic [3:0]             sel;
    logic [`LCRS_ADR_W-1:0] adr;
    logic [31:0]            dat;
  } lcrs_wb_req_type;

  typedef enum logic [2:0] {
    LCRS_OP_NONE   = 3'b000,
    LCRS_OP_EQ     = 3'b001,
    LCRS_OP_NE     = 3'b010,
    LCRS_OP_RSUB   = 3'b011,
    LCRS_OP_RSUBI3 = 3'b100,
    LCRS_OP_RSUBI2 = 3'b101
  } lcrs_op_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [63:0] opa;
    logic [63:0] opb;
    logic [63:0] opd;
    logic [47:0] pfx;
    logic        pfx_v;
    logic [31:0] insn;
    logic        carry;
    logic        illegal;
    logic        nopfx;
  } lcrs_state_type;
endpackage : lcrs_pkg

// ### lcrs_alu.sv
// Long compare and reverse-subtract execution unit behind a Wishbone slave
// Assumes classic Wishbone master on clk_i; writing INSN executes it at once
// Contract
// - Equal compare writes one when identical
// - Not-equal compare writes zero when identical
// - Compares exist only when enable parameter is one
// - Register form computes second minus first source
// - Instruction bit 3 selects keep carry
// - Instruction bit 4 selects carry input
// - Keep carry leaves flag unchanged
// - Otherwise flag takes 64-bit carry out
// - Add inverse subtrahend plus one or carry
// - Carry set means no borrow
// - Immediate form subtracts source or destination
// - Immediate controls at bits 3/13, 4/14
// - Immediate is sign extended or prefix extended
`timescale 1ns/1ns
module lcrs_alu #(
  parameter int pattern_compare_enable_param = 1
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  input  wire lcrs_pkg::lcrs_wb_req_type wb_i,
  output logic                          wb_ack_o,
  output logic [31:0]                   wb_dat_o,
  output logic                          carry_flag_o,
  output logic [63:0]                   dest_value_o
);
  `include "lcrs_consts.svh"

  lcrs_pkg::lcrs_state_type st;
  lcrs_pkg::lcrs_state_type next_st;
  lcrs_pkg::lcrs_op_type    op;

  logic        req;
  logic        wr_go;
  logic        exec_go;
  logic [31:0] insn_w;
  logic        is_eq;
  logic        is_ne;
  logic        is_rsub;
  logic        is_rsubi3;
  logic        is_rsubi2;
  logic        keep;
  logic        cin_sel;
  logic        cin;
  logic        pcmp_ok;
  logic [63:0] imm64;
  logic [63:0] minuend;
  logic [63:0] subtr;
  logic [64:0] sum;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = wdat[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  assign req     = wb_i.cyc && wb_i.stb;
  // Write lands on the edge where ack is sampled high
  assign wr_go   = req && st.ack && wb_i.we;
  assign exec_go = wr_go && (wb_i.adr == `LCRS_ADR_INSN);
  assign insn_w  = merge(st.insn, wb_i.dat, wb_i.sel);

  assign pcmp_ok   = (pattern_compare_enable_param == 1);
  assign is_eq     = (insn_w[31:26] == `LCRS_OPC_PCMP_EQ) && (insn_w[10:0] == `LCRS_FN_PCMP);
  assign is_ne     = (insn_w[31:26] == `LCRS_OPC_PCMP_NE) && (insn_w[10:0] == `LCRS_FN_PCMP);
  assign is_rsub   = (insn_w[31:29] == 3'h0) && insn_w[26] && (insn_w[10:0] == `LCRS_FN_RSUB);
  assign is_rsubi3 = (insn_w[31:29] == 3'h1) && insn_w[26];
  assign is_rsubi2 = (insn_w[31:26] == `LCRS_OPC_RSUBI2) && (insn_w[20:19] == 2'h0) && insn_w[16];

  assign op = is_eq     ? lcrs_pkg::LCRS_OP_EQ :
              is_ne     ? lcrs_pkg::LCRS_OP_NE :
              is_rsub   ? lcrs_pkg::LCRS_OP_RSUB :
              is_rsubi3 ? lcrs_pkg::LCRS_OP_RSUBI3 :
              is_rsubi2 ? lcrs_pkg::LCRS_OP_RSUBI2 : lcrs_pkg::LCRS_OP_NONE;

  // Two-operand immediate form moves its controls into the register field
  assign keep    = is_rsubi2 ? insn_w[`LCRS_BIT_K13] : insn_w[`LCRS_BIT_K3];
  assign cin_sel = is_rsubi2 ? insn_w[`LCRS_BIT_C14] : insn_w[`LCRS_BIT_C4];

  // Prefix supplies the upper 48 bits; without it the field is sign extended
  assign imm64 = st.pfx_v ? {st.pfx, insn_w[15:0]} : {{48{insn_w[15]}}, insn_w[15:0]};

  assign minuend = is_rsub ? st.opb : imm64;
  assign subtr   = is_rsubi2 ? st.opd : st.opa;
  assign cin     = cin_sel ? st.carry : 1'b1;
  // Carry out high means no borrow
  assign sum     = {1'b0, minuend} + {1'b0, ~subtr} + {64'h0, cin};

  always_comb begin
    next_st = st;
    next_st.ack = req && !st.ack;
    if (req && !st.ack) begin
      case (wb_i.adr)
        `LCRS_ADR_OPA_LO: next_st.rdat = st.opa[31:0];
        `LCRS_ADR_OPA_HI: next_st.rdat = st.opa[63:32];
        `LCRS_ADR_OPB_LO: next_st.rdat = st.opb[31:0];
        `LCRS_ADR_OPB_HI: next_st.rdat = st.opb[63:32];
        `LCRS_ADR_DST_LO: next_st.rdat = st.opd[31:0];
        `LCRS_ADR_DST_HI: next_st.rdat = st.opd[63:32];
        `LCRS_ADR_INSN:   next_st.rdat = st.insn;
        `LCRS_ADR_PFX_LO: next_st.rdat = st.pfx[31:0];
        `LCRS_ADR_PFX_HI: next_st.rdat = {16'h0, st.pfx[47:32]};
        `LCRS_ADR_STATUS: next_st.rdat = {28'h0, st.pfx_v, st.nopfx, st.illegal, st.carry};
        default:          next_st.rdat = 32'h0;
      endcase
    end
    if (wr_go) begin
      case (wb_i.adr)
        `LCRS_ADR_OPA_LO: next_st.opa[31:0]  = merge(st.opa[31:0], wb_i.dat, wb_i.sel);
        `LCRS_ADR_OPA_HI: next_st.opa[63:32] = merge(st.opa[63:32], wb_i.dat, wb_i.sel);
        `LCRS_ADR_OPB_LO: next_st.opb[31:0]  = merge(st.opb[31:0], wb_i.dat, wb_i.sel);
        `LCRS_ADR_OPB_HI: next_st.opb[63:32] = merge(st.opb[63:32], wb_i.dat, wb_i.sel);
        `LCRS_ADR_DST_LO: next_st.opd[31:0]  = merge(st.opd[31:0], wb_i.dat, wb_i.sel);
        `LCRS_ADR_DST_HI: next_st.opd[63:32] = merge(st.opd[63:32], wb_i.dat, wb_i.sel);
        `LCRS_ADR_INSN:   next_st.insn = insn_w;
        `LCRS_ADR_PFX_LO: begin
          next_st.pfx[31:0] = merge(st.pfx[31:0], wb_i.dat, wb_i.sel);
          next_st.pfx_v     = 1'b1;
        end
        `LCRS_ADR_PFX_HI: begin
          next_st.pfx[47:32] = 16'(merge({16'h0, st.pfx[47:32]}, wb_i.dat, wb_i.sel));
          next_st.pfx_v      = 1'b1;
        end
        `LCRS_ADR_STATUS: begin
          if (wb_i.sel[0]) begin
            next_st.carry = wb_i.dat[`LCRS_ST_CARRY];
            if (wb_i.dat[`LCRS_ST_ILLEGAL]) begin
              next_st.illegal = 1'b0;
            end
            if (wb_i.dat[`LCRS_ST_NOPFX]) begin
              next_st.nopfx = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    // Execution completes within the write cycle itself
    if (exec_go) begin
      next_st.pfx_v = 1'b0;
      case (op)
        lcrs_pkg::LCRS_OP_EQ,
        lcrs_pkg::LCRS_OP_NE: begin
          if (pcmp_ok) begin
            next_st.opd = {63'h0, (st.opa == st.opb) ^ (op == lcrs_pkg::LCRS_OP_NE)};
          end else begin
            next_st.illegal = 1'b1;
          end
        end
        lcrs_pkg::LCRS_OP_RSUB,
        lcrs_pkg::LCRS_OP_RSUBI3,
        lcrs_pkg::LCRS_OP_RSUBI2: begin
          next_st.opd = sum[63:0];
          if (!keep) begin
            next_st.carry = sum[64];
          end
          // Missing prefix still executes with a sign-extended value
          if (op == lcrs_pkg::LCRS_OP_RSUBI3 && !st.pfx_v) begin
            next_st.nopfx = 1'b1;
          end
        end
        default: next_st.illegal = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st       <= '0;
      st.carry <= `LCRS_RST_CARRY;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign wb_ack_o     = st.ack;
  assign wb_dat_o     = st.rdat;
  assign carry_flag_o = st.carry;
  assign dest_value_o = st.opd;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic go;
  assign go = exec_go && ce_i;

  sequence exec_s(lcrs_pkg::lcrs_op_type k);
    go && op == k;
  endsequence

  sequence sub_s;
    go && (is_rsub || is_rsubi3 || is_rsubi2);
  endsequence

  sequence bus_wr_s(logic [7:0] a);
    wr_go && ce_i && wb_i.adr == a;
  endsequence

  sequence bus_rd_s(logic [7:0] a);
    req && !st.ack && ce_i && !wb_i.we && wb_i.adr == a;
  endsequence

  eq_result_a: assert property (exec_s(lcrs_pkg::LCRS_OP_EQ) ##0 pcmp_ok |=>
    st.opd == {63'h0, $past(st.opa) == $past(st.opb)})
    else $error("equal compare result wrong");

  ne_result_a: assert property (exec_s(lcrs_pkg::LCRS_OP_NE) ##0 pcmp_ok |=>
    st.opd == {63'h0, $past(st.opa) != $past(st.opb)})
    else $error("not-equal compare result wrong");

  pcmp_absent_a: assert property ((exec_s(lcrs_pkg::LCRS_OP_EQ) or exec_s(lcrs_pkg::LCRS_OP_NE))
    ##0 !pcmp_ok |=> st.illegal && $stable(st.opd))
    else $error("compare ran while disabled");

  rsub_value_a: assert property (exec_s(lcrs_pkg::LCRS_OP_RSUB) ##0 !cin_sel |=>
    st.opd == $past(st.opb) - $past(st.opa))
    else $error("reverse subtract value wrong");

  keep_bit_a: assert property (go && is_rsub |-> keep == insn_w[`LCRS_BIT_K3]
    && cin_sel == insn_w[`LCRS_BIT_C4])
    else $error("register form control bits wrong");

  keep_carry_a: assert property (sub_s ##0 keep |=> $stable(st.carry))
    else $error("carry changed under keep");

  carry_load_a: assert property (exec_s(lcrs_pkg::LCRS_OP_RSUB) ##0 !keep && !cin_sel |=>
    st.carry == ($past(st.opb) >= $past(st.opa)))
    else $error("carry not loaded as no-borrow");

  carry_in_a: assert property (exec_s(lcrs_pkg::LCRS_OP_RSUB) ##0 cin_sel |=>
    st.opd == $past(st.opb) + ~$past(st.opa) + {63'h0, $past(st.carry)})
    else $error("carry input not used");

  imm_two_op_a: assert property (exec_s(lcrs_pkg::LCRS_OP_RSUBI2) ##0 !cin_sel |=>
    st.opd == $past(imm64) - $past(st.opd))
    else $error("two-operand immediate wrong");

  imm_ctrl_a: assert property (go && is_rsubi2 |-> keep == insn_w[`LCRS_BIT_K13]
    && cin_sel == insn_w[`LCRS_BIT_C14])
    else $error("immediate form control bits wrong");

  // Checked end to end so a broken extension shows in the result
  imm_ext_a: assert property (exec_s(lcrs_pkg::LCRS_OP_RSUBI2) ##0 !st.pfx_v && !cin_sel |=>
    st.opd == {{48{$past(insn_w[15])}}, $past(insn_w[15:0])} - $past(st.opd))
    else $error("immediate not sign extended");

  imm_pfx_a: assert property (exec_s(lcrs_pkg::LCRS_OP_RSUBI3) ##0 st.pfx_v && !cin_sel |=>
    st.opd == {$past(st.pfx), $past(insn_w[15:0])} - $past(st.opa))
    else $error("prefix not used as upper immediate");

  imm_three_a: assert property (exec_s(lcrs_pkg::LCRS_OP_RSUBI3) ##0 !cin_sel |=>
    st.opd == $past(imm64) - $past(st.opa))
    else $error("three-operand immediate wrong");

  nopfx_set_a: assert property (exec_s(lcrs_pkg::LCRS_OP_RSUBI3) ##0 !st.pfx_v |=> st.nopfx)
    else $error("missing prefix not flagged");

  pfx_clear_a: assert property (go |=> !st.pfx_v)
    else $error("prefix survived an instruction");

  pfx_set_a: assert property (bus_wr_s(`LCRS_ADR_PFX_LO) ##0 !exec_go |=> st.pfx_v)
    else $error("prefix write did not mark valid");

  illegal_op_a: assert property (exec_s(lcrs_pkg::LCRS_OP_NONE) |=>
    st.illegal && $stable(st.opd) && $stable(st.carry))
    else $error("unknown instruction altered state");

  carry_imm_a: assert property (sub_s ##0 !keep && !cin_sel |=>
    st.carry == ($past(minuend) >= $past(subtr)))
    else $error("immediate carry not no-borrow");

  sub_srcs_a: assert property (sub_s |=> $stable(st.opa) && $stable(st.opb))
    else $error("subtract altered a source");

  quiet_hold_a: assert property (ce_i && !wr_go |=> $stable(st.opd) && $stable(st.carry))
    else $error("result changed without a write");

  ce_freeze_a: assert property (!ce_i |=> $stable(st))
    else $error("state moved with enable low");

  ack_idle_a: assert property (!req && ce_i |=> !st.ack)
    else $error("ack without a request");

  opa_read_a: assert property (bus_rd_s(`LCRS_ADR_OPA_LO) |=> st.rdat == $past(st.opa[31:0]))
    else $error("operand read data wrong");

  status_read_a: assert property (bus_rd_s(`LCRS_ADR_STATUS) |=>
    st.rdat == {28'h0, $past(st.pfx_v), $past(st.nopfx), $past(st.illegal), $past(st.carry)})
    else $error("status read data wrong");

  unmapped_read_a: assert property (req && !st.ack && ce_i && wb_i.adr > `LCRS_ADR_STATUS |=> st.rdat == 32'h0)
    else $error("unmapped read not zero");

  dst_write_a: assert property (bus_wr_s(`LCRS_ADR_DST_LO) ##0 wb_i.sel == 4'hf |=>
    st.opd[31:0] == $past(wb_i.dat))
    else $error("destination write lost");

  opa_write_a: assert property (bus_wr_s(`LCRS_ADR_OPA_HI) ##0 wb_i.sel == 4'hf |=>
    st.opa[63:32] == $past(wb_i.dat))
    else $error("operand write lost");

  status_wr_a: assert property (bus_wr_s(`LCRS_ADR_STATUS) ##0 wb_i.sel[0] |=>
    st.carry == $past(wb_i.dat[`LCRS_ST_CARRY]))
    else $error("carry write lost");

  illegal_clr_a: assert property (bus_wr_s(`LCRS_ADR_STATUS) ##0 wb_i.sel[0] && wb_i.dat[`LCRS_ST_ILLEGAL] |=>
    !st.illegal)
    else $error("illegal flag not cleared");

  nopfx_clr_a: assert property (bus_wr_s(`LCRS_ADR_STATUS) ##0 wb_i.sel[0] && wb_i.dat[`LCRS_ST_NOPFX] |=>
    !st.nopfx)
    else $error("missing prefix flag not cleared");

  cmp_only_dst_a: assert property ((exec_s(lcrs_pkg::LCRS_OP_EQ) or exec_s(lcrs_pkg::LCRS_OP_NE))
    |=> $stable(st.carry) && $stable(st.opa) && $stable(st.opb))
    else $error("compare altered more than destination");

  wb_ack_a: assert property (req && !st.ack && ce_i |=> st.ack ##1 (!st.ack || !ce_i))
    else $error("ack not a single cycle answer");
endmodule : lcrs_alu

// ### lcrs_wb_master.sv
// Classic Wishbone master standing in for the decode stage
// Assumes a slave on clk_i that acks every request once
`timescale 1ns/1ns
module lcrs_wb_master (
  input  wire logic                 clk_i,
  input  wire logic                 ack_i,
  input  wire logic [31:0]          dat_i,
  output lcrs_pkg::lcrs_wb_req_type wb_o
);
  initial wb_o = '0;

  // Ack and data read at the rising edge, before the slave's update lands
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      input logic [3:0] sel, output logic [31:0] rd);
    @(posedge clk_i);
    wb_o <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: wd};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    rd = dat_i;
    wb_o.cyc <= 1'b0;
    wb_o.stb <= 1'b0;
  endtask : xfer
endmodule : lcrs_wb_master

// ### long_compare_reverse_subtract_alu_tb.sv
// Self-checking bench for the long compare / reverse-subtract unit
// Assumes lcrs_pkg and lcrs_wb_master compiled first
`timescale 1ns/1ns
module long_compare_reverse_subtract_alu_tb;
  logic                      clk_i = 1'b0;
  logic                      rst_i = 1'b1;
  logic                      ce_i  = 1'b1;
  lcrs_pkg::lcrs_wb_req_type wb;
  logic                      wb_ack;
  logic                      carry;
  logic [31:0]               wb_dat;
  logic [63:0]               dest;
  int                        errors = 0;
  int                        checks = 0;
  int                        seed   = 32'h8322;

  always #20 clk_i = ~clk_i;

  lcrs_alu #(.pattern_compare_enable_param(1)) i_lcrs_alu (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_i(wb), .wb_ack_o(wb_ack), .wb_dat_o(wb_dat), .carry_flag_o(carry), .dest_value_o(dest));
  lcrs_wb_master i_lcrs_wb_master (.clk_i(clk_i), .ack_i(wb_ack), .dat_i(wb_dat), .wb_o(wb));

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic [31:0] r;
    i_lcrs_wb_master.xfer(1'b1, a, d, s, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    i_lcrs_wb_master.xfer(1'b0, a, 32'h0, 4'hf, d);
  endtask : rd

  task automatic wr64(input logic [7:0] a, input logic [63:0] v);
    wr(a, v[31:0]);
    wr(a + 8'h04, v[63:32]);
  endtask : wr64

  // Minuend plus inverted subtrahend plus carry in; bit 64 is no-borrow
  function automatic logic [64:0] rsub(input logic [63:0] m, input logic [63:0] s, input logic cin);
    return {1'b0, m} + {1'b0, ~s} + {64'h0, cin};
  endfunction : rsub

  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    wrap_up;
  end

  initial begin
    logic [63:0] a, b, d, imm, exp;
    logic [47:0] pfx;
    logic [31:0] insn, r;
    logic        k, c, cy, expc;
    int          op;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("dest_rst", dest, 64'h0);
    chk("carry_rst", {63'h0, carry}, 64'h0);
    @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    rd(8'h3c, r);
    chk("unmapped", {32'h0, r}, 64'h0);
    wr(8'h18, 32'hfc000000);
    rd(8'h24, r);
    chk("illegal", {61'h0, r[2:0]}, 64'h2);
    chk("dest_kept", dest, 64'h0);
    wr(8'h24, 32'h2, 4'h1);
    // Three-operand form with no prefix: sign extended, flagged
    wr(8'h18, {3'b001, 2'b00, 1'b1, 10'h0, 16'h8001});
    @(negedge clk_i);
    chk("noprefix_dest", dest, 64'hffffffffffff8001);
    rd(8'h24, r);
    chk("noprefix_status", {60'h0, r[3:0]}, 64'h5);
    wr(8'h24, 32'h4, 4'h1);
    wr(8'h1c, 32'h1);
    rd(8'h24, r);
    chk("prefix_valid", {60'h0, r[3:0]}, 64'h8);
    for (int i = 0; i < 40; i++) begin
      a = {$random(seed), $random(seed)};
      b = (i % 4 == 0) ? a : {$random(seed), $random(seed)};
      d = {$random(seed), $random(seed)};
      pfx = 48'({$random(seed), $random(seed)});
      insn = $random(seed);
      {k, c, cy} = insn[2:0];
      // First twenty sweep every carry control pair over every op
      if (i < 20) {k, c} = 2'(i / 5);
      op = i % 5;
      wr64(8'h00, a);
      wr64(8'h08, b);
      wr64(8'h10, d);
      wr(8'h24, {31'h0, cy}, 4'h1);
      imm = {{48{insn[15]}}, insn[15:0]};
      case (op)
        0: insn = {6'h22, 15'h0, 11'h500};
        1: insn = {6'h23, 15'h0, 11'h500};
        2: insn = {3'b000, k, c, 1'b1, 15'h0, 11'h100};
        3: begin
          wr(8'h1c, pfx[31:0]);
          wr(8'h20, {16'h0, pfx[47:32]});
          imm = {pfx, insn[15:0]};
          insn = {3'b001, k, c, 1'b1, 10'h0, insn[15:0]};
        end
        default: insn = {6'h1a, 7'h0, k, c, 1'b1, insn[15:0]};
      endcase
      case (op)
        0: {expc, exp} = {cy, 63'h0, a == b};
        1: {expc, exp} = {cy, 63'h0, a != b};
        2: {expc, exp} = rsub(b, a, c ? cy : 1'b1);
        3: {expc, exp} = rsub(imm, a, c ? cy : 1'b1);
        default: {expc, exp} = rsub(imm, d, c ? cy : 1'b1);
      endcase
      if (k || op < 2) expc = cy;
      wr(8'h18, insn);
      @(negedge clk_i);
      chk("dest", dest, exp);
      chk("carry", {63'h0, carry}, {63'h0, expc});
      rd(8'h24, r);
      chk("status", {61'h0, r[2:0]}, {61'h0, 2'b00, expc});
    end
    wrap_up;
  end
endmodule : long_compare_reverse_subtract_alu_tb
